// ### rtl/tmc_transport.sv
// Transport end: decodes controller strobes into rewind, unload, reverse
`timescale 1ns/1ps
// Functional notes
// - Rewind = rewind level plus function strobe
// - Rewind set fires 12 us pulse if permitted
// - Eject permit when both motion latches clear
// - Mechanics finish rewind without further help
// - Beginning marker both polarities, inhibits rewind pulse
// - Motion going idle starts 5 ms settle
// - Settle expiry raises unit ready
// - Unload request starts timer only with eject permit
// - Unload pulse commands rewind, sets eject latch
// - Settle end with eject sets reverse latch
// - Reverse latch drives reverse actuator
// - Remote to local change gives one clear
// - Master clear resets motion and write latches
// - Reverse request sets only if forward clear, no rewind
// - Reverse latch lights panel reverse lamp
// - End of data in reverse drives return line
// - Move negation without eject gives function clear
// - Local reset clears write enable directly
// - Local reset rising triggers master clear
// - Local reset halts remote or manual motion
// - Operator resets locally before manual controls
// - Select-remote qualifier gates controller operations
module tmc_transport #(
  parameter int unsigned CLK_HZ = tmc_pkg::CLK_HZ_DEF,
  parameter int unsigned SETTLE_CYCLES = tmc_pkg::SETTLE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  tmc_link_if.dev   link,
  input  wire logic i_auto_mode,
  input  wire logic i_local_reset,
  input  wire logic i_rewind_status,
  input  wire logic i_bot_marker,
  input  wire logic i_write_enable_set,
  input  wire logic i_forward_set,
  output logic      o_rewind_command_pulse,
  output logic      o_reverse_command,
  output logic      o_reverse_lamp,
  output logic      o_bot_marker_seen,
  output logic      o_bot_marker_seen_n,
  output logic      o_write_enable_latch,
  output logic      o_forward_motion_latch,
  output logic      o_tape_eject_latch,
  output logic      o_general_clear_pulse
);
  import tmc_pkg::*;

  localparam int unsigned NIN = 11;
  localparam int unsigned CMD_CYC =
    (CMD_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic [NIN-1:0] s3_r;
  logic [NIN-1:0] lvl_r;
  logic [NIN-1:0] prev_r;

  assign raw = {link.function_strobe, link.rewind_request_level,
                link.unload_level, link.reverse_level, link.motion_hold,
                link.end_of_data_flag, link.unit_select, i_auto_mode,
                i_local_reset, i_rewind_status, i_bot_marker};

  // Level counts once second and third stage agree
  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          lvl_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            lvl_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl_r;
    end
  end

  logic fn_p, rew_l, unl_l, rev_l, mov_l, eod_l, sel_l, auto_l;
  logic lrst_l, rwst_l, bot_l;
  assign {fn_p, rew_l, unl_l, rev_l, mov_l, eod_l, sel_l, auto_l,
          lrst_l, rwst_l, bot_l} = lvl_r;

  logic fn_rise, mov_fall, auto_fall, lrst_rise;
  assign fn_rise   = fn_p & ~prev_r[10];
  assign mov_fall  = ~mov_l & prev_r[6];
  assign auto_fall = ~lvl_r[3] & prev_r[3];
  assign lrst_rise = lvl_r[2] & ~prev_r[2];

  logic sel_remote;
  assign sel_remote = auto_l & sel_l;

  logic fwd_r, rev_r, eject_r, wen_r, clr_r;
  logic eject_permit;
  assign eject_permit = ~fwd_r & ~rev_r;

  logic rewind_set, unload_set, reverse_req, func_clr, master_clr;
  assign rewind_set  = fn_rise & rew_l & sel_remote;
  assign unload_set  = fn_rise & unl_l & sel_remote & eject_permit;
  assign reverse_req = fn_rise & rev_l & sel_remote;
  assign func_clr    = mov_fall & ~eject_r;
  assign master_clr  = auto_fall | lrst_rise | (func_clr & sel_remote);

  // One counter serves both 12 us pulses
  logic [$clog2(CMD_CYC+1)-1:0] cmd_cnt_r;
  logic                         cmd_unload_r;
  logic                         rew_pulse_r;
  logic                         cmd_start;
  assign cmd_start = (cmd_cnt_r == '0) & ~bot_l &
                     ((rewind_set & eject_permit) | unload_set);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_cnt_r    <= '0;
      cmd_unload_r <= 1'b0;
      rew_pulse_r  <= 1'b0;
    end else if (cmd_start) begin
      cmd_cnt_r    <= ($clog2(CMD_CYC+1))'(CMD_CYC);
      cmd_unload_r <= unload_set;
      rew_pulse_r  <= 1'b1;
    end else if (cmd_cnt_r != '0) begin
      cmd_cnt_r   <= cmd_cnt_r - 1'b1;
      rew_pulse_r <= (cmd_cnt_r != 1) & ~bot_l;
    end else begin
      rew_pulse_r  <= 1'b0;
      cmd_unload_r <= 1'b0;
    end
  end

  // Motion idle: no rewind running and both latches clear
  logic idle_now, idle_prev_r;
  assign idle_now = ~rwst_l & eject_permit;

  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_r;
  logic settle_done, ready_r;
  assign settle_done = (settle_r == 1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_prev_r <= 1'b1;
      settle_r    <= '0;
    end else begin
      idle_prev_r <= idle_now;
      if (idle_now & ~idle_prev_r) begin
        settle_r <= ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES);
      end else if (settle_r != '0) begin
        settle_r <= settle_r - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ready_r <= 1'b0;
    end else if (settle_done) begin
      ready_r <= 1'b1;
    end else if (~idle_now | (settle_r != '0) | fn_rise) begin
      ready_r <= 1'b0;
    end
  end

  // Motion latches; clear wins since it halts the tape
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rev_r <= 1'b0;
    end else if (master_clr | bot_l & ~eject_r | rwst_l) begin
      rev_r <= 1'b0;
    end else if (settle_done & eject_r) begin
      rev_r <= 1'b1;
    end else if (reverse_req & ~fwd_r & ~rwst_l) begin
      rev_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fwd_r <= 1'b0;
    end else if (master_clr | rwst_l) begin
      fwd_r <= 1'b0;
    end else if (i_forward_set & ~rev_r) begin
      fwd_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      eject_r <= 1'b0;
    end else if (lrst_rise | auto_fall) begin
      eject_r <= 1'b0;
    end else if (cmd_start & unload_set) begin
      eject_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wen_r <= 1'b0;
    end else if (lrst_l | master_clr | rwst_l | settle_done) begin
      wen_r <= 1'b0;
    end else if (i_write_enable_set & sel_remote) begin
      wen_r <= 1'b1;
    end
  end

  logic ret_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ret_r <= 1'b0;
      clr_r <= 1'b0;
    end else begin
      ret_r <= rev_r & eod_l & sel_remote;
      clr_r <= master_clr;
    end
  end

  // Both polarities from flops so neither output glitches
  logic bot_r;
  logic bot_n_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bot_r   <= 1'b0;
      bot_n_r <= 1'b1;
    end else begin
      bot_r   <= bot_l;
      bot_n_r <= ~bot_l;
    end
  end

  assign link.unit_ready         = ready_r;
  assign link.read_return_line_b = ret_r;
  assign o_rewind_command_pulse  = rew_pulse_r;
  assign o_reverse_command       = rev_r;
  assign o_reverse_lamp          = rev_r;
  assign o_bot_marker_seen       = bot_r;
  assign o_bot_marker_seen_n     = bot_n_r;
  assign o_write_enable_latch    = wen_r;
  assign o_forward_motion_latch  = fwd_r;
  assign o_tape_eject_latch      = eject_r;
  assign o_general_clear_pulse   = clr_r;
endmodule

// ### rtl/tmc_pkg.sv
// Shared constants for the tape motion command logic and its controller end
package tmc_pkg;
  localparam int unsigned CLK_HZ_DEF    = 100_000_000;
  localparam int unsigned CMD_PULSE_NS  = 12_000;
  localparam int unsigned SETTLE_MS     = 5;
  // Least times round up to whole cycles
  localparam int unsigned CMD_PULSE_CYC =
    (CMD_PULSE_NS * (CLK_HZ_DEF / 1_000_000) + 999) / 1000;
  localparam int unsigned SETTLE_CYC    = SETTLE_MS * (CLK_HZ_DEF / 1000);
  localparam int unsigned STRB_CYC      = 2;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam logic [1:0]  RET_RESET     = 2'h0;
endpackage

// ### rtl/tmc_link_if.sv
// Wires between the tape controller and the transport command logic
`timescale 1ns/1ps
interface tmc_link_if;
  logic function_strobe;
  logic rewind_request_level;
  logic unload_level;
  logic reverse_level;
  logic motion_hold;
  logic end_of_data_flag;
  logic unit_select;
  logic unit_ready;
  logic read_return_line_b;

  modport dev (
    input  function_strobe,
    input  rewind_request_level,
    input  unload_level,
    input  reverse_level,
    input  motion_hold,
    input  end_of_data_flag,
    input  unit_select,
    output unit_ready,
    output read_return_line_b
  );
  modport ctl (
    output function_strobe,
    output rewind_request_level,
    output unload_level,
    output reverse_level,
    output motion_hold,
    output end_of_data_flag,
    output unit_select,
    input  unit_ready,
    input  read_return_line_b
  );
endinterface

// ### rtl/tmc_controller.sv
// Controller end: turns user commands into strobes and levels on the link
`timescale 1ns/1ps
module tmc_controller (
  input  wire logic i_clk,
  input  wire logic i_rst,
  tmc_link_if.ctl   link,
  input  wire logic i_cmd_valid,
  input  wire logic [1:0] i_cmd_kind,
  input  wire logic i_select,
  input  wire logic i_move,
  input  wire logic i_end_of_data,
  output logic      o_cmd_ready,
  output logic      o_unit_ready,
  output logic      o_return_b
);
  import tmc_pkg::*;

  // Kind: 0 rewind, 1 unload, 2 reverse
  typedef enum logic [1:0] {
    TMC_IDLE = 2'b01,
    TMC_STRB = 2'b10
  } tmc_state_e;

  tmc_state_e state_r;
  logic [1:0] cnt_r;
  logic       rew_r, unl_r, revl_r, fn_r;
  logic       s1_r, s2_r, s3_r, ur_r;
  logic       b1_r, b2_r, b3_r, rb_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= TMC_IDLE;
      cnt_r   <= '0;
      fn_r    <= 1'b0;
      rew_r   <= 1'b0;
      unl_r   <= 1'b0;
      revl_r  <= 1'b0;
    end else begin
      unique case (state_r)
        TMC_IDLE: begin
          fn_r <= 1'b0;
          if (i_cmd_valid) begin
            rew_r   <= (i_cmd_kind == 2'h0);
            unl_r   <= (i_cmd_kind == 2'h1);
            revl_r  <= (i_cmd_kind == 2'h2);
            cnt_r   <= 2'(STRB_CYC);
            state_r <= TMC_STRB;
          end
        end
        TMC_STRB: begin
          fn_r  <= (cnt_r != '0);
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == '0) begin
            state_r <= TMC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      ur_r <= 1'b0;
      b1_r <= 1'b0;
      b2_r <= 1'b0;
      b3_r <= 1'b0;
      rb_r <= 1'b0;
    end else begin
      s1_r <= link.unit_ready;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) ur_r <= s3_r;
      b1_r <= link.read_return_line_b;
      b2_r <= b1_r;
      b3_r <= b2_r;
      if (b2_r == b3_r) rb_r <= b3_r;
    end
  end

  logic mv_r, eod_r, sel_r, rdy_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mv_r  <= 1'b0;
      eod_r <= 1'b0;
      sel_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      mv_r  <= i_move;
      eod_r <= i_end_of_data;
      sel_r <= i_select;
      rdy_r <= (state_r == TMC_IDLE) & ~i_cmd_valid;
    end
  end

  assign link.function_strobe      = fn_r;
  assign link.rewind_request_level = rew_r;
  assign link.unload_level         = unl_r;
  assign link.reverse_level        = revl_r;
  assign link.motion_hold          = mv_r;
  assign link.end_of_data_flag     = eod_r;
  assign link.unit_select          = sel_r;
  assign o_cmd_ready  = rdy_r;
  assign o_unit_ready = ur_r;
  assign o_return_b   = rb_r;
endmodule

// ### dv/tmc_chk_sva.sv
// Checker on the link wires and transport outputs
`timescale 1ns/1ps
module tmc_chk #(
  parameter int unsigned SETTLE_CYCLES = tmc_pkg::SETTLE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rewind_status,
  input wire logic function_strobe,
  input wire logic unit_ready,
  input wire logic read_return_line_b,
  input wire logic o_rewind_command_pulse,
  input wire logic o_reverse_command,
  input wire logic o_reverse_lamp,
  input wire logic o_bot_marker_seen,
  input wire logic o_bot_marker_seen_n,
  input wire logic o_write_enable_latch,
  input wire logic o_forward_motion_latch,
  input wire logic o_tape_eject_latch,
  input wire logic o_general_clear_pulse
);
  import tmc_pkg::*;
  logic        idle;
  logic        idle_q;
  logic [15:0] hi_cnt;
  logic [31:0] since_idle;
  assign idle = !o_forward_motion_latch && !o_reverse_command
    && !i_rewind_status;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_cnt <= '0;
    end else if (o_rewind_command_pulse) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end else begin
      hi_cnt <= '0;
    end
  end
  // Saturates so a long idle spell never wraps below the settle count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_q     <= 1'b0;
      since_idle <= '0;
    end else begin
      idle_q <= idle;
      if (idle && !idle_q) since_idle <= '0;
      else if (since_idle != 32'hffff_ffff) since_idle <= since_idle + 32'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_pulse_len: assert property (
    $fell(o_rewind_command_pulse) |-> hi_cnt == CMD_PULSE_CYC)
    else $error("rewind pulse length wrong");
  a_pulse_permit: assert property (
    $rose(o_rewind_command_pulse) |->
      $past(!o_forward_motion_latch && !o_reverse_command))
    else $error("rewind pulse while reels move");
  a_bot_inhibit: assert property (
    $rose(o_rewind_command_pulse) |-> !$past(o_bot_marker_seen))
    else $error("rewind pulse with marker seen");
  a_bot_both: assert property (
    o_bot_marker_seen_n == !o_bot_marker_seen)
    else $error("marker polarities disagree");
  a_lamp_follow: assert property (
    o_reverse_lamp == o_reverse_command)
    else $error("reverse lamp differs");
  a_settle_ready: assert property (
    $rose(unit_ready) |-> since_idle >= SETTLE_CYCLES)
    else $error("unit ready before settling");
  a_strobe_width: assert property (
    $rose(function_strobe) |=> function_strobe)
    else $error("function strobe too short");
  a_clear_latches: assert property (
    o_general_clear_pulse |=> !o_forward_motion_latch && !o_reverse_command
      && !o_write_enable_latch && !o_tape_eject_latch)
    else $error("latch survived a clear");
  a_return_rev: assert property (
    $rose(read_return_line_b) |-> o_reverse_command)
    else $error("return line without reverse");
  c_rewind: cover property ($rose(o_rewind_command_pulse));
  c_ready: cover property ($rose(unit_ready));
  c_clear: cover property (o_general_clear_pulse);
endmodule

// ### dv/tape_motion_command_logic_tb_top.sv
// Self-checking bench joining the controller and transport ends
`timescale 1ns/1ps
module tape_motion_command_logic_tb_top;
  import tmc_pkg::*;
  localparam int unsigned SETTLE = 50;
  logic i_clk, i_rst, i_cmd_valid, i_select, i_move, i_end_of_data;
  logic i_auto_mode, i_local_reset, i_rewind_status, i_bot_marker;
  logic i_write_enable_set, i_forward_set, o_cmd_ready, o_unit_ready;
  logic o_return_b, o_rewind_command_pulse, o_reverse_command;
  logic o_reverse_lamp, o_bot_marker_seen, o_bot_marker_seen_n;
  logic o_write_enable_latch, o_forward_motion_latch, o_tape_eject_latch;
  logic o_general_clear_pulse;
  logic [1:0] i_cmd_kind;
  int mismatches = 0, num_checks = 0, rew_n = 0, clr_n = 0, cyc = 0;
  tmc_link_if i_tmc_link_if ();
  tmc_transport #(.SETTLE_CYCLES(SETTLE)) i_tmc_transport (
    .i_clk, .i_rst, .link(i_tmc_link_if), .i_auto_mode, .i_local_reset,
    .i_rewind_status, .i_bot_marker, .i_write_enable_set, .i_forward_set,
    .o_rewind_command_pulse, .o_reverse_command, .o_reverse_lamp,
    .o_bot_marker_seen, .o_bot_marker_seen_n, .o_write_enable_latch,
    .o_forward_motion_latch, .o_tape_eject_latch, .o_general_clear_pulse);
  tmc_controller i_tmc_controller (
    .i_clk, .i_rst, .link(i_tmc_link_if), .i_cmd_valid, .i_cmd_kind,
    .i_select, .i_move, .i_end_of_data, .o_cmd_ready, .o_unit_ready,
    .o_return_b);
  tmc_chk #(.SETTLE_CYCLES(SETTLE)) i_tmc_chk (
    .i_clk, .i_rst, .i_rewind_status,
    .function_strobe(i_tmc_link_if.function_strobe),
    .unit_ready(i_tmc_link_if.unit_ready),
    .read_return_line_b(i_tmc_link_if.read_return_line_b),
    .o_rewind_command_pulse, .o_reverse_command, .o_reverse_lamp,
    .o_bot_marker_seen, .o_bot_marker_seen_n, .o_write_enable_latch,
    .o_forward_motion_latch, .o_tape_eject_latch, .o_general_clear_pulse);
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge o_rewind_command_pulse) rew_n++;
  always @(posedge o_general_clear_pulse) clr_n++;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run length is a few thousand cycles; this only catches a hang
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk_bit(input logic got, input logic exp, input string s);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp, input string s);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return o_rewind_command_pulse;
      1: return o_unit_ready;
      2: return o_reverse_command;
      default: return o_return_b;
    endcase
  endfunction
  task automatic wt(input int w, input int lim);
    for (int n = 0; n < lim && sig(w) !== 1'b1; n++) tk(1);
  endtask
  // Ready is read settled at the falling edge; one rising edge takes it,
  // so a held valid can never start a second command
  task automatic issue(input logic [1:0] k);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 50) begin
      tk(1);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      $display("ERROR %0t cmd ready got %h exp %h", $time, o_cmd_ready, 1'b1);
    end
    i_cmd_kind = k;
    i_cmd_valid = 1'b1;
    tk(1);
    i_cmd_valid = 1'b0;
  endtask
  task automatic rew_pulse(output int n);
    n = 0;
    wt(0, 30);
    while (o_rewind_command_pulse === 1'b1 && n < 2000) begin
      tk(1);
      n++;
    end
  endtask
  task automatic fin(input string s);
    $display("%s done: checks %0d mismatches %0d", s, num_checks, mismatches);
  endtask
  task automatic t_rewind();
    int n;
    issue(2'h0);
    rew_pulse(n);
    chk_cnt(n, CMD_PULSE_CYC, "rewind width");
    i_rewind_status = 1'b1;
    tk(10);
    i_bot_marker = 1'b1;
    i_rewind_status = 1'b0;
    tk(SETTLE / 2);
    chk_bit(o_bot_marker_seen, 1'b1, "marker");
    chk_bit(o_bot_marker_seen_n, 1'b0, "marker_n");
    chk_bit(o_unit_ready, 1'b0, "early ready");
    wt(1, SETTLE);
    chk_bit(o_unit_ready, 1'b1, "ready");
    fin("rewind");
  endtask
  task automatic t_refuse();
    int r0;
    r0 = rew_n;
    issue(2'h0);
    tk(30);
    chk_cnt(rew_n - r0, 0, "rewind at marker");
    i_bot_marker = 1'b0;
    i_forward_set = 1'b1;
    tk(1);
    i_forward_set = 1'b0;
    tk(3);
    chk_bit(o_forward_motion_latch, 1'b1, "forward");
    issue(2'h0);
    tk(30);
    chk_cnt(rew_n - r0, 0, "rewind moving");
    issue(2'h2);
    tk(20);
    chk_bit(o_reverse_command, 1'b0, "reverse on fwd");
    r0 = clr_n;
    i_move = 1'b0;
    tk(20);
    chk_cnt(clr_n - r0, 1, "move clear");
    chk_bit(o_forward_motion_latch, 1'b0, "fwd cleared");
    i_move = 1'b1;
    tk(SETTLE + 20);
    fin("refuse");
  endtask
  task automatic t_reverse();
    issue(2'h2);
    wt(2, 30);
    chk_bit(o_reverse_command, 1'b1, "reverse");
    chk_bit(o_reverse_lamp, 1'b1, "lamp");
    i_end_of_data = 1'b1;
    wt(3, 30);
    chk_bit(o_return_b, 1'b1, "return b");
    i_move = 1'b0;
    tk(20);
    chk_bit(o_reverse_command, 1'b0, "reverse stop");
    i_end_of_data = 1'b0;
    i_move = 1'b1;
    tk(SETTLE + 20);
    fin("reverse");
  endtask
  task automatic t_unload();
    int n;
    issue(2'h1);
    rew_pulse(n);
    chk_cnt(n, CMD_PULSE_CYC, "unload width");
    chk_bit(o_tape_eject_latch, 1'b1, "eject");
    i_rewind_status = 1'b1;
    tk(10);
    i_rewind_status = 1'b0;
    wt(2, SETTLE + 30);
    chk_bit(o_reverse_command, 1'b1, "pull off");
    n = clr_n;
    i_auto_mode = 1'b0;
    tk(20);
    chk_cnt(clr_n - n, 1, "auto clear");
    chk_bit(o_reverse_command, 1'b0, "rev clr");
    i_auto_mode = 1'b1;
    tk(SETTLE + 20);
    fin("unload");
  endtask
  task automatic t_local();
    int c0;
    i_write_enable_set = 1'b1;
    tk(1);
    i_write_enable_set = 1'b0;
    i_forward_set = 1'b1;
    tk(1);
    i_forward_set = 1'b0;
    tk(3);
    chk_bit(o_write_enable_latch, 1'b1, "write en");
    c0 = clr_n;
    i_local_reset = 1'b1;
    tk(10);
    chk_bit(o_write_enable_latch, 1'b0, "write off");
    chk_bit(o_forward_motion_latch, 1'b0, "halt");
    chk_cnt(clr_n - c0, 1, "local clear");
    i_local_reset = 1'b0;
    tk(10);
    fin("local");
  endtask
  initial begin
    {i_cmd_valid, i_cmd_kind, i_end_of_data, i_local_reset} = '0;
    {i_rewind_status, i_bot_marker, i_write_enable_set} = '0;
    i_forward_set = 1'b0;
    {i_select, i_move, i_auto_mode, i_rst} = 4'hf;
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    tk(10);
    t_rewind();
    t_refuse();
    t_reverse();
    t_unload();
    t_local();
    complete_run();
  end
endmodule
